// *** bpc_defines.svh ***
// constants for the protocol unit codec: octet layout, codes and lengths
// assumes inclusion by the package and by the codec module only
`ifndef BPC_DEFINES_SVH
`define BPC_DEFINES_SVH

// field widths
`define BPC_BID_W    64
`define BPC_COST_W   32
`define BPC_PID_W    16
`define BPC_TIMER_W  16
`define BPC_FRAME_W  280

// fixed header values
`define BPC_PROTO_ID 16'h0000
`define BPC_VERSION  8'h00
`define BPC_TYPE_CFG 8'h00
`define BPC_TYPE_TCN 8'h80

// flag bit positions within the flag octet (bit 1 = index 0)
`define BPC_FLAG_TCA 7
`define BPC_FLAG_TC  0

// unit lengths and octet numbers
`define BPC_CFG_LEN  6'h23
`define BPC_TCN_LEN  6'h04
`define BPC_PID_OCT  6'h02
`define BPC_CNT_SAT  6'h24

// timer fields count in 1/256 s
`define BPC_TIMER_HZ 256

// reset value of octet registers
`define BPC_RST_OCT  8'h00

`endif

// *** bpc_pkg.sv ***
// types shared by the protocol unit codec and its tests
// assumes bpc_defines.svh is on the include path
`include "bpc_defines.svh"

package bpc_pkg;

   // decoded or to-be-encoded configuration unit
   typedef struct packed {
      logic                      tc_ack;
      logic                      tc;
      logic [`BPC_BID_W-1:0]     root_id;
      logic [`BPC_COST_W-1:0]    path_cost;
      logic [`BPC_BID_W-1:0]     bridge_id;
      logic [`BPC_PID_W-1:0]     port_id;
      logic [`BPC_TIMER_W-1:0]   msg_age;
      logic [`BPC_TIMER_W-1:0]   max_age;
      logic [`BPC_TIMER_W-1:0]   hello_time;
      logic [`BPC_TIMER_W-1:0]   fwd_delay;
   } bpc_cfg_t;

   // one octet of a unit on the wire, with end marker
   typedef struct packed {
      logic       last;
      logic [7:0] octet;
   } bpc_oct_t;

   typedef enum logic [0:0] {
      BPC_TX_IDLE = 1'b0,
      BPC_TX_SEND = 1'b1
   } bpc_tx_state_t;

endpackage : bpc_pkg

// *** bpc_fifo.sv ***
// small flip-flop fifo with valid/ready on both sides
// assumes a single clock and synchronous active-low reset
module bpc_fifo #(
   parameter int W     = 9,
   parameter int DEPTH = 4
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   import bpc_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_ent
         always_ff @(posedge core_clk) begin
            if (!rst_b) begin
               mem_q[gi] <= '0;
            end else if (push && (wr_q == AW'(gi))) begin
               mem_q[gi] <= in_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

endmodule : bpc_fifo

// *** bpc_cmp.sv ***
// unsigned priority compare: the lesser value has the higher priority
// assumes both operands are stable register outputs
module bpc_cmp #(
   parameter int W = 64
) (
   // operands
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   // result
   output logic              a_better,
   output logic              same
);
   import bpc_pkg::*;

   assign a_better = (a < b);
   assign same     = (a == b);

endmodule : bpc_cmp

// *** bpc_codec.sv ***
// protocol unit codec: builds and parses configuration and
// topology change notification units as octet streams
// assumes octet streams come from logic on core_clk
`include "bpc_defines.svh"
module bpc_codec #(
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst_b,
   // bridge settings
   input  wire logic [15:0]              bridge_prio,
   input  wire logic [47:0]              bridge_mac,
   input  wire logic [7:0]               port_prio,
   input  wire logic [7:0]               port_num,
   output logic [`BPC_BID_W-1:0]         own_bridge_id,
   output logic [`BPC_PID_W-1:0]         own_port_id,
   // transmit request
   input  wire logic                     tx_req,
   input  wire logic                     tx_tcn,
   input  wire bpc_pkg::bpc_cfg_t        tx_fields,
   output logic                          tx_busy,
   output logic                          tx_refused,
   // transmit octets
   output logic                          tx_valid,
   input  wire logic                     tx_ready,
   output bpc_pkg::bpc_oct_t             tx_oct,
   // receive octets
   input  wire logic                     rx_valid,
   input  wire bpc_pkg::bpc_oct_t        rx_oct,
   // receive results
   output bpc_pkg::bpc_cfg_t             rx_fields,
   output logic                          rx_is_tcn,
   output logic [7:0]                    rx_version,
   output logic                          rx_accept,
   output logic                          rx_discard,
   output logic                          rx_root_better,
   output logic                          rx_port_better
);
   import bpc_pkg::*;

   // own identifiers
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         own_bridge_id <= '0;
         own_port_id   <= '0;
      end else begin
         // address octet one lands in id octet three, bits as is
         own_bridge_id <= {bridge_prio, bridge_mac};
         own_port_id   <= {port_prio, port_num};
      end
   end

   // transmit side
   bpc_tx_state_t            tx_state_q;
   logic [`BPC_FRAME_W-1:0]  tx_sr_q;
   logic [5:0]               tx_left_q;
   logic [5:0]               tx_len_q;
   logic                     tx_tcn_q;
   logic                     tx_refused_q;
   logic                     tx_take;
   logic                     tx_bad;
   logic                     tx_push;
   logic                     fifo_in_ready;
   logic [5:0]               tx_octnum;
   logic [7:0]               tx_flags;
   logic [`BPC_FRAME_W-1:0]  tx_cfg_frame;
   logic [`BPC_FRAME_W-1:0]  tx_tcn_frame;
   bpc_oct_t                 tx_in;

   assign tx_take  = (tx_state_q == BPC_TX_IDLE) && tx_req;
   assign tx_bad   = !tx_tcn &&
                     ((tx_fields.msg_age >= tx_fields.max_age) ||
                      (port_num == 8'h00));
   assign tx_push  = (tx_state_q == BPC_TX_SEND) && fifo_in_ready;
   assign tx_busy  = (tx_state_q == BPC_TX_SEND);
   assign tx_refused = tx_refused_q;
   assign tx_octnum  = 6'(tx_len_q - tx_left_q + 6'h01);

   always_comb begin
      tx_flags = '0;
      tx_flags[`BPC_FLAG_TCA] = tx_fields.tc_ack;
      tx_flags[`BPC_FLAG_TC]  = tx_fields.tc;
   end

   // header, then fields, most significant octet first
   assign tx_cfg_frame = {`BPC_PROTO_ID,
                          `BPC_VERSION,
                          `BPC_TYPE_CFG,
                          tx_flags,
                          tx_fields.root_id,
                          tx_fields.path_cost,
                          own_bridge_id,
                          own_port_id,
                          tx_fields.msg_age,
                          tx_fields.max_age,
                          tx_fields.hello_time,
                          tx_fields.fwd_delay};
   assign tx_tcn_frame = {`BPC_PROTO_ID, `BPC_VERSION,
                          `BPC_TYPE_TCN,
                          {(`BPC_FRAME_W-32){1'b0}}};

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tx_state_q <= BPC_TX_IDLE;
      end else begin
         case (tx_state_q)
            BPC_TX_IDLE: begin
               if (tx_take && !tx_bad) begin
                  tx_state_q <= BPC_TX_SEND;
               end
            end
            BPC_TX_SEND: begin
               if (tx_push && (tx_left_q == 6'h01)) begin
                  tx_state_q <= BPC_TX_IDLE;
               end
            end
            default: begin
               tx_state_q <= BPC_TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tx_sr_q   <= '0;
         tx_left_q <= '0;
         tx_len_q  <= '0;
         tx_tcn_q  <= 1'b0;
      end else if (tx_take && !tx_bad) begin
         tx_sr_q   <= tx_tcn ? tx_tcn_frame : tx_cfg_frame;
         tx_left_q <= tx_tcn ? `BPC_TCN_LEN : `BPC_CFG_LEN;
         tx_len_q  <= tx_tcn ? `BPC_TCN_LEN : `BPC_CFG_LEN;
         tx_tcn_q  <= tx_tcn;
      end else if (tx_push) begin
         tx_sr_q   <= {tx_sr_q[`BPC_FRAME_W-9:0], `BPC_RST_OCT};
         tx_left_q <= tx_left_q - 6'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tx_refused_q <= 1'b0;
      end else begin
         tx_refused_q <= tx_take && tx_bad;
      end
   end

   assign tx_in.last  = (tx_left_q == 6'h01);
   assign tx_in.octet = tx_sr_q[`BPC_FRAME_W-1 -: 8];

   bpc_fifo #(
      .W     ($bits(bpc_oct_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .in_valid  (tx_state_q == BPC_TX_SEND),
      .in_ready  (fifo_in_ready),
      .in_data   (tx_in),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (tx_oct)
   );

   // receive side
   logic [`BPC_FRAME_W-9:0]  rx_sr_q;
   logic [5:0]               rx_cnt_q;
   logic                     rx_done_q;
   logic                     rx_pid_ok_q;
   logic [5:0]               rx_n;
   logic [`BPC_FRAME_W-1:0]  rx_full;
   logic                     rx_acc_d;
   logic                     rx_dis_d;
   logic                     rx_tcn_d;
   bpc_cfg_t                 rx_dec;
   bpc_cfg_t                 rx_fields_q;
   logic                     rx_is_tcn_q;
   logic [7:0]               rx_version_q;
   logic                     rx_accept_q;
   logic                     rx_discard_q;

   // fields of a full unit, octet k at bits 287-8k down
   always_comb begin
      rx_full          = {rx_sr_q, rx_oct.octet};
      rx_dec.tc_ack    = rx_full[247 - (7 - `BPC_FLAG_TCA)];
      rx_dec.tc        = rx_full[240 + `BPC_FLAG_TC];
      rx_dec.root_id   = rx_full[239:176];
      rx_dec.path_cost = rx_full[175:144];
      rx_dec.bridge_id = rx_full[143:80];
      rx_dec.port_id   = rx_full[79:64];
      rx_dec.msg_age   = rx_full[63:48];
      rx_dec.max_age   = rx_full[47:32];
      rx_dec.hello_time = rx_full[31:16];
      rx_dec.fwd_delay = rx_full[15:0];
   end

   always_comb begin
      rx_n     = (rx_cnt_q == `BPC_CNT_SAT) ? `BPC_CNT_SAT
                                            : rx_cnt_q + 6'h01;
      rx_acc_d = 1'b0;
      rx_dis_d = 1'b0;
      rx_tcn_d = 1'b0;
      if (rx_valid && !rx_done_q) begin
         if (rx_n == `BPC_TCN_LEN) begin
            // version octet is not looked at
            if (!rx_pid_ok_q) begin
               rx_dis_d = 1'b1;
            end else if (rx_oct.octet == `BPC_TYPE_TCN) begin
               rx_acc_d = 1'b1;
               rx_tcn_d = 1'b1;
            end else if (rx_oct.octet != `BPC_TYPE_CFG) begin
               rx_dis_d = 1'b1;
            end
         end else if (rx_n == `BPC_CFG_LEN) begin
            if (rx_dec.msg_age < rx_dec.max_age) begin
               rx_acc_d = 1'b1;
            end else begin
               rx_dis_d = 1'b1;
            end
         end
         if (rx_oct.last && !rx_acc_d) begin
            rx_dis_d = 1'b1;
         end
      end
   end

   // octet count and decision state per unit
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rx_cnt_q    <= '0;
         rx_done_q   <= 1'b0;
         rx_pid_ok_q <= 1'b0;
      end else if (rx_valid) begin
         if (rx_oct.last) begin
            rx_cnt_q    <= '0;
            rx_done_q   <= 1'b0;
            rx_pid_ok_q <= 1'b0;
         end else begin
            rx_cnt_q  <= rx_n;
            // trailing octets are dropped once decided
            rx_done_q <= rx_done_q || rx_acc_d || rx_dis_d;
            if (rx_n == `BPC_PID_OCT) begin
               rx_pid_ok_q <= ({rx_sr_q[7:0], rx_oct.octet} ==
                               `BPC_PROTO_ID);
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rx_sr_q <= '0;
      end else if (rx_valid && !rx_done_q) begin
         rx_sr_q <= {rx_sr_q[`BPC_FRAME_W-17:0], rx_oct.octet};
      end
   end

   // results
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rx_accept_q  <= 1'b0;
         rx_discard_q <= 1'b0;
      end else begin
         rx_accept_q  <= rx_acc_d;
         rx_discard_q <= rx_dis_d;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         rx_fields_q  <= '0;
         rx_is_tcn_q  <= 1'b0;
         rx_version_q <= `BPC_RST_OCT;
      end else if (rx_acc_d) begin
         rx_is_tcn_q  <= rx_tcn_d;
         rx_version_q <= rx_tcn_d ? rx_sr_q[7:0] : rx_full[263:256];
         if (!rx_tcn_d) begin
            rx_fields_q <= rx_dec;
         end
      end
   end

   assign rx_fields  = rx_fields_q;
   assign rx_is_tcn  = rx_is_tcn_q;
   assign rx_version = rx_version_q;
   assign rx_accept  = rx_accept_q;
   assign rx_discard = rx_discard_q;

   // priority compares against own identifiers
   bpc_cmp #(
      .W (`BPC_BID_W)
   ) u_cmp_root (
      .a        (rx_fields_q.root_id),
      .b        (own_bridge_id),
      .a_better (rx_root_better),
      .same     ()
   );
   bpc_cmp #(
      .W (`BPC_PID_W)
   ) u_cmp_port (
      .a        (rx_fields_q.port_id),
      .b        (own_port_id),
      .a_better (rx_port_better),
      .same     ()
   );
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   tx_proto_zero_a: assert property (tx_push && tx_octnum <= 6'h02 |->
      tx_in.octet == 8'h00) else $error("protocol id octet not zero");
   tx_version_a: assert property (tx_push && tx_octnum == 6'h03 |->
      tx_in.octet == 8'h00) else $error("version octet not zero");
   tx_type_a: assert property (tx_push && tx_octnum == 6'h04 |->
      tx_in.octet == (tx_tcn_q ? 8'h80 : 8'h00)) else $error("bad type octet");
   tx_flags_a: assert property (tx_push && tx_octnum == 6'h05 |->
      tx_in.octet[6:1] == 6'h00) else $error("unused flag bit set");
   tx_unit_len_a: assert property (tx_push && tx_in.last |->
      tx_octnum == (tx_tcn_q ? 6'h04 : 6'h23)) else $error("bad unit length");
   tx_age_refuse_a: assert property (tx_take && !tx_tcn &&
      tx_fields.msg_age >= tx_fields.max_age |=> tx_refused && !tx_busy)
      else $error("bad age not refused");
   tx_port_zero_a: assert property (tx_take && !tx_tcn &&
      port_num == 8'h00 |=> tx_refused) else $error("port zero not refused");
   rx_short_a: assert property (rx_valid && rx_oct.last &&
      rx_cnt_q < 6'h03 |=> rx_discard) else $error("short unit not discarded");
   rx_age_ok_a: assert property (rx_accept && !rx_is_tcn |->
      rx_fields.msg_age < rx_fields.max_age) else $error("age not below max");
   rx_tcn_at4_a: assert property (rx_accept && rx_is_tcn |->
      $past(rx_cnt_q) == 6'h03) else $error("notification decided late");
   rx_once_a: assert property (rx_accept |=> !rx_accept &&
      (!rx_discard || $past(rx_valid && rx_oct.last && rx_cnt_q == 6'h00)))
      else $error("second decision for one unit");
   rx_excl_a: assert property (!(rx_accept && rx_discard))
      else $error("accept and discard together");
   cfg_seen_c: cover property (rx_accept && !rx_is_tcn);
   tcn_seen_c: cover property (rx_accept && rx_is_tcn);
   discard_c:  cover property (rx_discard);
   fifo_full_c: cover property (tx_busy && !fifo_in_ready);

endmodule : bpc_codec

// *** bpc_peer.sv ***
// peer bridge model: takes sent octets, sends received units
// assumes it drives its outputs at the falling edge of core_clk
module bpc_peer (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // octets from the codec
   input  wire logic              tx_valid,
   output logic                   tx_ready,
   input  wire bpc_pkg::bpc_oct_t tx_oct,
   // octets to the codec
   output logic                   rx_valid,
   output bpc_pkg::bpc_oct_t      rx_oct
);
   timeunit 1ns;
   timeprecision 1ns;
   import bpc_pkg::*;
   logic [8:0] got[$];
   int         mode = 0;
   int         seed = 53;
   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_oct   = '0;
   end
   // 0 takes all, 1 stalls at random, 2 stalls
   always @(negedge core_clk) begin
      tx_ready = mode == 0 || (mode == 1 && $random(seed) % 2 == 0);
   end
   always @(posedge core_clk) begin
      if (rst_b && tx_valid && tx_ready) begin
         got.push_back(tx_oct);
      end
   end
   // idle line shows the inverse of its last value
   task automatic send_unit(input logic [7:0] u[$], input bit keep);
      for (int i = 0; i < u.size(); i++) begin
         @(negedge core_clk);
         while (mode == 1 && $random(seed) % 3 == 0) begin
            rx_valid = 1'b0;
            rx_oct   = ~rx_oct;
            @(negedge core_clk);
         end
         rx_valid = 1'b1;
         rx_oct   = {i == u.size() - 1, u[i]};
      end
      if (!keep) begin
         @(negedge core_clk);
         rx_valid = 1'b0;
         rx_oct   = ~rx_oct;
      end
   endtask : send_unit
endmodule : bpc_peer

// *** bpc_codec_tb.sv ***
// self-checking bench for the protocol unit codec
// assumes bpc_peer stands at the far side of both octet streams
module bpc_codec_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import bpc_pkg::*;
   typedef logic [7:0] bpc_octq_t[$];
   logic         core_clk;
   logic         rst_b;
   logic [15:0]  bridge_prio;
   logic [47:0]  bridge_mac;
   logic [7:0]   port_prio;
   logic [7:0]   port_num;
   logic [63:0]  own_bridge_id;
   logic [15:0]  own_port_id;
   logic         tx_req;
   logic         tx_tcn;
   bpc_cfg_t     tx_fields;
   logic         tx_busy;
   logic         tx_refused;
   logic         tx_valid;
   logic         tx_ready;
   bpc_oct_t     tx_oct;
   logic         rx_valid;
   bpc_oct_t     rx_oct;
   bpc_cfg_t     rx_fields;
   logic         rx_is_tcn;
   logic [7:0]   rx_version;
   logic         rx_accept;
   logic         rx_discard;
   logic         rx_root_better;
   logic         rx_port_better;
   int           n_errors = 0;
   int           checked = 0;
   int           seed = 53;
   int           n_acc = 0;
   int           n_dis = 0;
   int           n_ref = 0;

   bpc_codec bpc_codec_i (.core_clk, .rst_b, .bridge_prio, .bridge_mac,
      .port_prio, .port_num, .own_bridge_id, .own_port_id, .tx_req,
      .tx_tcn, .tx_fields, .tx_busy, .tx_refused, .tx_valid, .tx_ready,
      .tx_oct, .rx_valid, .rx_oct, .rx_fields, .rx_is_tcn, .rx_version,
      .rx_accept, .rx_discard, .rx_root_better, .rx_port_better);
   bpc_peer bpc_peer_i (.core_clk, .rst_b, .tx_valid, .tx_ready, .tx_oct,
      .rx_valid, .rx_oct);

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (rx_accept === 1'b1) n_acc++;
      if (rx_discard === 1'b1) n_dis++;
      if (tx_refused === 1'b1) n_ref++;
   end

   task automatic chk(input logic [255:0] got, input logic [255:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d, errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic req();
      tx_req = 1'b1;
      @(negedge core_clk);
      tx_req = 1'b0;
   endtask : req

   function automatic bpc_cfg_t rnd_cfg();
      logic [255:0] v;
      for (int i = 0; i < 8; i++) begin
         v = {v[223:0], 32'($random(seed))};
      end
      v[241 -: 2] = {v[1], v[0]};
      // message age below 16'h8000, max age is forced above it
      v[63] = 1'b0;
      return v[241:0];
   endfunction : rnd_cfg

   // unit image: octet 1 in the top eight bits
   function automatic logic [279:0] cfg_img(bpc_cfg_t f, logic [63:0] b,
                                            logic [15:0] p);
      return {32'h0, f.tc_ack, 6'h00, f.tc, f.root_id, f.path_cost,
              b, p, f.msg_age, f.max_age, f.hello_time, f.fwd_delay};
   endfunction : cfg_img

   function automatic bpc_octq_t to_q(logic [279:0] img, int n);
      bpc_octq_t q;
      for (int i = 0; i < n; i++) begin
         q.push_back(i < 35 ? img[279 - 8 * i -: 8] : 8'($random(seed)));
      end
      return q;
   endfunction : to_q

   initial begin
      bpc_cfg_t     f;
      bpc_cfg_t     ef;
      bpc_octq_t    q;
      logic [279:0] img;
      logic [63:0]  bid;
      logic [15:0]  pid;
      int           n;
      int           r;
      int           ea;
      int           ed;
      bit           lt;
      logic [7:0]   lv;
      rst_b = 1'b0;
      tx_req = 1'b0;
      tx_tcn = 1'b0;
      tx_fields = '0;
      {bridge_prio, bridge_mac, port_prio, port_num} = '0;
      repeat (2) @(negedge core_clk);
      chk(tx_valid, 1'b0);
      chk(rx_accept, 1'b0);
      rst_b = 1'b1;
      // transmit: stalls, fifo full, both unit kinds
      for (int k = 0; k < 12; k++) begin
         bridge_prio = 16'($random(seed));
         bridge_mac = {16'($random(seed)), 32'($random(seed))};
         port_prio = 8'($random(seed));
         port_num = 8'($random(seed)) | 8'h01;
         f = rnd_cfg();
         f.max_age[15] = 1'b1;
         tx_fields = f;
         tx_tcn = k % 4 == 3;
         bpc_peer_i.mode = k % 3;
         bid = {bridge_prio, bridge_mac};
         pid = {port_prio, port_num};
         repeat (2) @(negedge core_clk);
         chk(own_bridge_id, bid);
         chk(own_port_id, pid);
         img = tx_tcn ? {32'h0000_0080, 248'h0} : cfg_img(f, bid, pid);
         n = tx_tcn ? 4 : 35;
         req();
         if (k % 3 == 2) begin
            repeat (20) @(negedge core_clk);
            chk(tx_valid, 1'b1);
            chk(bpc_peer_i.got.size(), 0);
            bpc_peer_i.mode = 1;
         end
         r = 0;
         while (bpc_peer_i.got.size() < n && r < 600) begin
            @(negedge core_clk);
            r++;
         end
         repeat (3) @(negedge core_clk);
         chk(bpc_peer_i.got.size(), n);
         for (int i = 0; i < n && i < bpc_peer_i.got.size(); i++) begin
            chk(bpc_peer_i.got[i], {i == n - 1, img[279 - 8 * i -: 8]});
         end
         bpc_peer_i.got.delete();
      end
      // refused configuration requests, notification never refused
      tx_tcn = 1'b0;
      f.max_age = f.msg_age;
      tx_fields = f;
      req();
      repeat (3) @(negedge core_clk);
      chk(n_ref, 1);
      port_num = 8'h00;
      f.max_age = f.msg_age + 16'h0001;
      tx_fields = f;
      repeat (2) @(negedge core_clk);
      req();
      repeat (3) @(negedge core_clk);
      chk(n_ref, 2);
      chk(bpc_peer_i.got.size(), 0);
      tx_tcn = 1'b1;
      bpc_peer_i.mode = 0;
      req();
      repeat (8) @(negedge core_clk);
      chk(n_ref, 2);
      chk(bpc_peer_i.got.size(), 4);
      // receive: every acceptance and discard case, some back to back
      port_num = 8'h80;
      pid = {port_prio, 8'h80};
      ea = 0;
      ed = 0;
      lt = 0;
      lv = 0;
      ef = '0;
      for (int k = 0; k < 42; k++) begin
         f = rnd_cfg();
         f.max_age[15] = 1'b1;
         r = k % 7;
         if (r == 3) f.max_age = f.msg_age;
         img = cfg_img(f, f.bridge_id, f.port_id);
         img[263:256] = 8'($random(seed));
         n = 35 + k % 3;
         case (r)
            0: begin
               img[255:248] = 8'h80;
               n = 4 + k % 3;
            end
            2: n = 34;
            4: img[264] = 1'b1;
            5: n = 1 + k % 3;
            6: img[255:248] = {1'b0, 7'(k | 1)};
            default: ;
         endcase
         q = to_q(img, n);
         bpc_peer_i.mode = k % 2;
         bpc_peer_i.send_unit(q, k % 4 == 1);
         if (n >= 4 && q[0] == 0 && q[1] == 0 && (q[3] == 8'h80 ||
             (q[3] == 0 && n >= 35 && {q[27], q[28]} < {q[29], q[30]})))
         begin
            ea++;
            lt = q[3] == 8'h80;
            lv = q[2];
            if (!lt) ef = {q[4][7], q[4][0], img[239:0]};
         end else begin
            ed++;
         end
         if (k % 4 != 1) begin
            repeat (3) @(negedge core_clk);
            chk(n_acc, ea);
            chk(n_dis, ed);
            chk(rx_is_tcn, lt);
            chk(rx_version, lv);
            chk(rx_fields, ef);
            chk(rx_root_better, ef.root_id < bid);
            chk(rx_port_better, ef.port_id < pid);
         end
      end
      tally_and_finish();
   end

   initial begin
      #2000000;
      n_errors++;
      tally_and_finish();
   end
endmodule : bpc_codec_tb
